// ---- common/dual_counter_pkg.sv ----
/*
  Shared definitions for the dual counter common control block: register
  offsets, field positions, field codes, reset values, timer counts and the
  packed structs that carry the register port and the block state.
  Assumes one clock domain and a byte-wide register port.
*/
package dual_counter_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CNT8_CTL = 8'h00;
  localparam logic [7:0] ADDR_SHARED = 8'h01;
  localparam logic [7:0] ADDR_RUN = 8'h03;
  localparam logic [7:0] ADDR_CNT8_VAL = 8'h04;
  localparam logic [7:0] ADDR_CAP_LO = 8'h05;
  localparam logic [7:0] ADDR_CAP_HI = 8'h06;

  // timer_shared_control fields
  localparam int MODE_BIT = 7;
  localparam int ROUTE_BIT = 6;
  localparam int COMB_LSB = 4;
  localparam int SUB_LSB = 2;
  localparam int INIT8_BIT = 1;
  localparam int INIT16_BIT = 0;

  // timer_run_control fields
  localparam int SYNC_BIT = 2;
  localparam int RUN8_BIT = 1;
  localparam int RUN16_BIT = 0;
  localparam logic [4:0] RUN_RSV_READ = 5'h1f;

  // eight_bit_counter_control fields
  localparam int TOUT_BIT = 5;
  localparam int CAPIE_BIT = 2;
  localparam int TOUTIE_BIT = 1;

  // Field codes
  localparam logic [1:0] COMB_AND = 2'h0;
  localparam logic [1:0] COMB_OR = 2'h1;
  localparam logic [1:0] COMB_NOR = 2'h2;
  localparam logic [1:0] COMB_NAND = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PINGPONG = 2'h1;
  localparam logic [1:0] SUB_FORCE0 = 2'h2;
  localparam logic [1:0] SUB_FORCE1 = 2'h3;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_SHORT = 2'h1;
  localparam logic [1:0] FILT_LONG = 2'h2;

  // Reset values and counts (filter widths in timer-clock cycles)
  localparam logic [7:0] SHARED_RST = 8'h00;
  localparam logic [7:0] CNT8_RELOAD = 8'hff;
  localparam logic [15:0] CNT16_RELOAD_DEF = 16'hffff;
  localparam logic [3:0] FILT_SHORT_TICKS = 4'h4;
  localparam logic [3:0] FILT_LONG_TICKS = 4'h8;
  localparam int TIMER_CLK_DIV_DEF = 2;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] shared;
    logic riseFlag;
    logic fallFlag;
    logic syncMode;
    logic run8;
    logic run16;
    logic capIe;
    logic toutIe;
    logic toutFlag;
    logic [7:0] cnt8;
    logic [15:0] cnt16;
    logic out8;
    logic out16;
    logic ppSel;
    logic [7:0] capLo;
    logic [7:0] capHi;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic filtLvl;
    logic [3:0] filtCnt;
    logic [7:0] div;
    logic [7:0] rdData;
    logic pinOut;
    logic capIrq;
    logic toutIrq;
    logic irqTwo;
  } state_s;

endpackage

// ---- hw/dual_counter_common_control.sv ----
/*
  Common control of an 8-bit and a 16-bit counter pair: transmit waveform
  generation, demodulation capture, pin routing, glitch filter, edge flags,
  run and sync control, registers on a plain strobe port.
  Assumes one clock, a synchronous reset, and pins that are asynchronous.
*/
`timescale 1ns/1ps

module dual_counter_common_control
  import dual_counter_pkg::*;
#(
  parameter int TIMER_CLK_DIV = TIMER_CLK_DIV_DEF,
  parameter logic [15:0] CNT16_RELOAD = CNT16_RELOAD_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire reg_req_s busReq,
  output logic [7:0] rdData,
  input wire logic port2Bit0In,
  input wire logic port3Bit1In,
  input wire logic portOutValue,
  output logic combinedOutPin,
  output logic captureIrq,
  output logic timeoutIrq,
  output logic extIrqTwo
);

  localparam logic [7:0] DIV_LAST = 8'(TIMER_CLK_DIV - 1);

  state_s st_r;
  state_s st_nxt;

  logic tick;
  logic demod;
  logic route;
  logic [1:0] comb;
  logic [1:0] sub;
  logic rawIn;
  logic [3:0] need;
  logic filtOn;
  logic rise;
  logic fall;
  logic capEv;
  logic act8;
  logic act16;
  logic merged;
  logic pingPong;

  always_comb begin
    st_nxt = st_r;
    st_nxt.capIrq = 1'b0;
    st_nxt.toutIrq = 1'b0;
    st_nxt.irqTwo = 1'b0;
    st_nxt.rdData = 8'h00;

    // Two-flop synchronisers, bit 1 for port 2, bit 0 for port 3
    st_nxt.sync1 = {port2Bit0In, port3Bit1In};
    st_nxt.sync2 = st_r.sync1;

    // Timer clock enable from the divider
    tick = (st_r.div == DIV_LAST);
    st_nxt.div = tick ? 8'h00 : st_r.div + 8'h01;

    demod = st_r.shared[MODE_BIT];
    route = st_r.shared[ROUTE_BIT];
    comb = st_r.shared[COMB_LSB +: 2];
    sub = st_r.shared[SUB_LSB +: 2];
    pingPong = !demod && (sub == SUB_PINGPONG);

    // Demodulator input choice
    rawIn = route ? st_r.sync2[1] : st_r.sync2[0];

    // Glitch filter; reserved code behaves as no filter
    filtOn = demod && (sub == FILT_SHORT || sub == FILT_LONG);
    need = (sub == FILT_SHORT) ? FILT_SHORT_TICKS : FILT_LONG_TICKS;
    if (!filtOn) begin
      st_nxt.filtLvl = rawIn;
      st_nxt.filtCnt = 4'h0;
    end else if (rawIn == st_r.filtLvl) begin
      st_nxt.filtCnt = 4'h0;
    end else if (tick) begin
      if (st_r.filtCnt + 4'h1 >= need) begin
        st_nxt.filtLvl = rawIn;
        st_nxt.filtCnt = 4'h0;
      end else begin
        st_nxt.filtCnt = st_r.filtCnt + 4'h1;
      end
    end
    rise = demod && !st_r.filtLvl && st_nxt.filtLvl;
    fall = demod && st_r.filtLvl && !st_nxt.filtLvl;

    // Edge selection
    unique case (comb)
      EDGE_FALL: capEv = fall;
      EDGE_RISE: capEv = rise;
      EDGE_BOTH: capEv = rise || fall;
      default: capEv = 1'b0;
    endcase
    capEv = capEv && st_r.run8;

    // Software writes come first so hardware sets win over clears
    if (busReq.wr) begin
      unique case (busReq.addr)
        ADDR_CNT8_CTL: begin
          st_nxt.capIe = busReq.wdata[CAPIE_BIT];
          st_nxt.toutIe = busReq.wdata[TOUTIE_BIT];
          if (busReq.wdata[TOUT_BIT]) begin
            st_nxt.toutFlag = 1'b0;
          end
        end
        ADDR_SHARED: begin
          st_nxt.shared[7:2] = busReq.wdata[7:2];
          if (demod) begin
            if (busReq.wdata[INIT8_BIT]) begin
              st_nxt.riseFlag = 1'b0;
            end
            if (busReq.wdata[INIT16_BIT]) begin
              st_nxt.fallFlag = 1'b0;
            end
          end else begin
            st_nxt.shared[1:0] = busReq.wdata[1:0];
          end
        end
        ADDR_RUN: begin
          st_nxt.syncMode = busReq.wdata[SYNC_BIT];
          // In sync mode starting either counter starts both
          st_nxt.run8 = busReq.wdata[RUN8_BIT]
                        || (busReq.wdata[SYNC_BIT] && busReq.wdata[RUN16_BIT]);
          st_nxt.run16 = busReq.wdata[RUN16_BIT]
                         || (busReq.wdata[SYNC_BIT] && busReq.wdata[RUN8_BIT]);
        end
        default: ;
      endcase
    end

    // A counter that starts takes its initial output level
    if (!st_r.run8 && st_nxt.run8) begin
      st_nxt.cnt8 = CNT8_RELOAD;
      st_nxt.out8 = st_r.shared[INIT8_BIT];
      st_nxt.ppSel = 1'b0;
    end
    if (!st_r.run16 && st_nxt.run16) begin
      st_nxt.cnt16 = CNT16_RELOAD;
      st_nxt.out16 = st_r.shared[INIT16_BIT];
    end

    act8 = st_r.run8 && st_nxt.run8 && (!pingPong || !st_r.ppSel);
    act16 = st_r.run16 && st_nxt.run16 && (!pingPong || st_r.ppSel);

    if (!demod) begin
      // Transmit: each counter toggles its output at terminal count
      if (tick && act8) begin
        if (st_r.cnt8 == 8'h00) begin
          st_nxt.cnt8 = CNT8_RELOAD;
          st_nxt.out8 = !st_r.out8;
          if (pingPong) begin
            st_nxt.ppSel = 1'b1;
          end
        end else begin
          st_nxt.cnt8 = st_r.cnt8 - 8'h01;
        end
      end
      if (tick && act16) begin
        if (st_r.cnt16 == 16'h0000) begin
          st_nxt.cnt16 = CNT16_RELOAD;
          st_nxt.out16 = !st_r.out16;
          if (pingPong) begin
            st_nxt.ppSel = 1'b0;
          end
        end else begin
          st_nxt.cnt16 = st_r.cnt16 - 16'h0001;
        end
      end
      if (sub == SUB_FORCE0) begin
        st_nxt.out16 = 1'b0;
      end else if (sub == SUB_FORCE1) begin
        st_nxt.out16 = 1'b1;
      end
    end else if (st_r.run8 && st_nxt.run8) begin
      // Demodulation: capture has priority over the count
      if (capEv) begin
        if (fall) begin
          st_nxt.capHi = st_r.cnt8;
          st_nxt.fallFlag = 1'b1;
        end else begin
          st_nxt.capLo = st_r.cnt8;
          st_nxt.riseFlag = 1'b1;
        end
        st_nxt.capIrq = st_r.capIe;
        st_nxt.irqTwo = !route;
        st_nxt.cnt8 = CNT8_RELOAD;
      end else if (tick) begin
        if (st_r.cnt8 == 8'h00) begin
          st_nxt.cnt8 = CNT8_RELOAD;
        end else begin
          st_nxt.cnt8 = st_r.cnt8 - 8'h01;
          if (st_r.cnt8 == 8'h01) begin
            st_nxt.toutFlag = 1'b1;
            st_nxt.toutIrq = st_r.toutIe;
          end
        end
      end
    end

    // Combine function for the shared pin
    unique case (comb)
      COMB_AND: merged = st_r.out8 && st_r.out16;
      COMB_OR: merged = st_r.out8 || st_r.out16;
      COMB_NOR: merged = !(st_r.out8 || st_r.out16);
      COMB_NAND: merged = !(st_r.out8 && st_r.out16);
    endcase
    if (demod || !route) begin
      st_nxt.pinOut = portOutValue;
    end else if (tick) begin
      st_nxt.pinOut = merged;
    end

    // Read data stands in the cycle after the strobe only
    if (busReq.rd) begin
      unique case (busReq.addr)
        ADDR_CNT8_CTL: st_nxt.rdData = {2'h0, st_r.toutFlag, 2'h0, st_r.capIe,
                                        st_r.toutIe, 1'b0};
        ADDR_SHARED: st_nxt.rdData = {st_r.shared[7:2],
                                      demod ? {st_r.riseFlag, st_r.fallFlag}
                                            : st_r.shared[1:0]};
        ADDR_RUN: st_nxt.rdData = {RUN_RSV_READ, st_r.syncMode, st_r.run8,
                                   st_r.run16};
        ADDR_CNT8_VAL: st_nxt.rdData = st_r.cnt8;
        ADDR_CAP_LO: st_nxt.rdData = st_r.capLo;
        ADDR_CAP_HI: st_nxt.rdData = st_r.capHi;
        default: st_nxt.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;
  assign combinedOutPin = st_r.pinOut;
  assign captureIrq = st_r.capIrq;
  assign timeoutIrq = st_r.toutIrq;
  assign extIrqTwo = st_r.irqTwo;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_DEMOD_HOLDS_OUT8: assert property (
    demod && $past(demod) && !busReq.wr |=> $stable(st_r.out8))
    else $error("8-bit output moved in demodulation");

  AST_PORT_ROUTE: assert property (
    !demod && !route |=> combinedOutPin == $past(portOutValue))
    else $error("Pin does not follow port output");

  AST_IRQ_TWO_SRC: assert property (
    extIrqTwo |-> $past(capEv) && !$past(route))
    else $error("Interrupt two without port3 capture");

  AST_FORCE16_LOW: assert property (
    !demod && sub == SUB_FORCE0 |=> !st_r.out16)
    else $error("16-bit output not forced low");

  AST_CAP_RELOAD: assert property (
    capEv |=> st_r.cnt8 == CNT8_RELOAD && !st_r.toutIrq)
    else $error("No reload after capture");

  AST_CAP_STORE: assert property (
    capEv && fall |=> st_r.capHi == $past(st_r.cnt8) && st_r.fallFlag)
    else $error("Falling capture not stored high");

  AST_TIMEOUT: assert property (
    demod && tick && !capEv && st_r.run8 && st_nxt.run8 && st_r.cnt8 == 8'h01
    |=> st_r.toutFlag && st_r.cnt8 == 8'h00 ##1 !st_r.toutIrq)
    else $error("Timeout not flagged at zero");

  AST_RISE_CLEAR: assert property (
    busReq.wr && busReq.addr == ADDR_SHARED && demod && busReq.wdata[1] && !rise
    |=> !st_r.riseFlag)
    else $error("Rising flag not cleared");

  AST_RUN_READ: assert property (
    busReq.rd && busReq.addr == ADDR_RUN
    |=> rdData[7:3] == RUN_RSV_READ ##1 rdData == 8'h00 || $past(busReq.rd))
    else $error("Run register upper bits not ones");

  AST_START8: assert property (
    busReq.wr && busReq.addr == ADDR_RUN && busReq.wdata[1] |=> st_r.run8)
    else $error("8-bit counter did not start");

  AST_CAP_IRQ: assert property (
    capEv && st_r.capIe |=> captureIrq ##1 !captureIrq || $past(capEv))
    else $error("Capture interrupt missing");

  COV_CAPTURE: cover property (demod && capEv ##1 captureIrq);
  COV_TIMEOUT: cover property (timeoutIrq);
  COV_PINGPONG: cover property (pingPong && st_r.ppSel ##[1:1000] !st_r.ppSel);
  COV_MERGED: cover property (!demod && route && tick && merged);

endmodule // dual_counter_common_control

// ---- verif/pulse_source.sv ----
/*
  Pulse source on the two demodulator input pins.
  Assumes one clock; the bench picks the pin in use and its level.
*/
`timescale 1ns/1ps

module pulse_source (
  input wire logic clock,
  input wire logic level,
  input wire logic useP2,
  output logic port2Bit0In,
  output logic port3Bit1In
);
  logic idleLvl_r = 1'b0;

  // The pin not in use keeps toggling, so a wrong pin choice shows up as edges
  always @(posedge clock) begin
    idleLvl_r <= ~idleLvl_r;
  end
  assign port2Bit0In = useP2 ? level : idleLvl_r;
  assign port3Bit1In = useP2 ? idleLvl_r : level;
endmodule // pulse_source

// ---- verif/test_dual_counter_common_control.sv ----
/*
  Self-checking bench for the dual counter common control block.
  Assumes the package register port and the pulse source on the input pins.
*/
`timescale 1ns/1ps

module test_dual_counter_common_control
  import dual_counter_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] rdExp;
    logic [2:0] flags;
  } row_s;

  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_s busReq = '0;
  logic [7:0] rdData;
  logic port2Bit0In;
  logic port3Bit1In;
  logic portOutValue = 1'b0;
  logic combinedOutPin;
  logic captureIrq;
  logic timeoutIrq;
  logic extIrqTwo;
  logic level = 1'b0;
  logic useP2 = 1'b0;
  logic [7:0] v;
  int failCount = 0;
  int samplesChecked = 0;
  // Flags: port level, check pin, pin value; port level opposes the merged value in every pin check but the first two rows
  row_s rows [23] = '{
    '{8'h01, 8'h00, 8'h00, 3'b111}, '{8'h01, 8'h00, 8'h00, 3'b010},
    '{8'h03, 8'h02, 8'hfa, 3'b000}, '{8'h03, 8'h01, 8'hf9, 3'b000},
    '{8'h03, 8'h00, 8'hf8, 3'b000}, '{8'h03, 8'h04, 8'hfc, 3'b000},
    '{8'h03, 8'h06, 8'hff, 3'b000}, '{8'h03, 8'hf8, 8'hf8, 3'b000},
    '{8'h02, 8'h55, 8'h00, 3'b000}, '{8'h03, 8'h01, 8'hf9, 3'b000},
    '{8'h01, 8'h48, 8'h48, 3'b110}, '{8'h01, 8'h5c, 8'h5c, 3'b011},
    '{8'h01, 8'h6c, 8'h6c, 3'b110}, '{8'h01, 8'h78, 8'h78, 3'b011},
    '{8'h03, 8'h00, 8'hf8, 3'b000}, '{8'h01, 8'h4e, 8'h4e, 3'b000},
    '{8'h03, 8'h02, 8'hfa, 3'b011}, '{8'h03, 8'h00, 8'hf8, 3'b000},
    '{8'h01, 8'h4c, 8'h4c, 3'b000}, '{8'h03, 8'h02, 8'hfa, 3'b110},
    '{8'h03, 8'h00, 8'hf8, 3'b000}, '{8'h01, 8'h43, 8'h43, 3'b000},
    '{8'h03, 8'h03, 8'hfb, 3'b011}};

  dual_counter_common_control dual_counter_common_control_inst (
    .clock(clock), .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData),
    .port2Bit0In(port2Bit0In), .port3Bit1In(port3Bit1In),
    .portOutValue(portOutValue), .combinedOutPin(combinedOutPin),
    .captureIrq(captureIrq), .timeoutIrq(timeoutIrq), .extIrqTwo(extIrqTwo));

  pulse_source pulse_source_inst (.clock(clock), .level(level), .useP2(useP2),
    .port2Bit0In(port2Bit0In), .port3Bit1In(port3Bit1In));

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1;
    v = rdData;
  endtask

  task automatic setLvl(input logic l);
    @(posedge clock);
    level <= l;
  endtask

  // Irq outputs are one-cycle pulses, so poll every cycle
  task automatic waitIrq(input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge clock);
      #1;
      if (captureIrq === 1'b1 || timeoutIrq === 1'b1) break;
    end
    chk("irq pulse", {7'h00, n < lim}, 8'h01);
  endtask

  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rd(ADDR_SHARED);
    chk("shared reset", v, SHARED_RST);
    rd(ADDR_RUN);
    chk("run reset", v, 8'hf8);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clock);
      portOutValue <= rows[i].flags[2];
      wr(rows[i].addr, rows[i].data);
      repeat (8) @(posedge clock);
      #1;
      if (rows[i].flags[1]) chk("pin", {7'h00, combinedOutPin}, {7'h00, rows[i].flags[0]});
      rd(rows[i].addr);
      chk("readback", v, rows[i].rdExp);
    end
    $display("test table done");
    wr(ADDR_RUN, 8'h02);
    wr(ADDR_CNT8_CTL, 8'h04);
    wr(ADDR_SHARED, 8'ha0);
    setLvl(1'b1);
    waitIrq(20);
    chk("irq two", {7'h00, extIrqTwo}, 8'h01);
    rd(ADDR_SHARED);
    chk("rise flag", v, 8'ha2);
    rd(ADDR_CNT8_VAL);
    chk("reload", {7'h00, v >= 8'hf0}, 8'h01);
    rd(ADDR_CAP_HI);
    chk("high idle", v, 8'h00);
    setLvl(1'b0);
    waitIrq(20);
    rd(ADDR_SHARED);
    chk("fall flag", v, 8'ha3);
    rd(ADDR_CAP_HI);
    chk("high capture", {7'h00, v >= 8'hf0}, 8'h01);
    wr(ADDR_SHARED, 8'ha2);
    rd(ADDR_SHARED);
    chk("rise clear", v, 8'ha1);
    wr(ADDR_SHARED, 8'ha1);
    rd(ADDR_SHARED);
    chk("fall clear", v, 8'ha0);
    wr(ADDR_SHARED, 8'h80);
    setLvl(1'b1);
    repeat (10) @(posedge clock);
    rd(ADDR_SHARED);
    chk("rise ignored", v, 8'h80);
    setLvl(1'b0);
    waitIrq(20);
    rd(ADDR_SHARED);
    chk("fall only", v, 8'h81);
    $display("test capture done");
    // Counter stopped while pins swap, so the idle pin's toggles cannot capture
    wr(ADDR_RUN, 8'h00);
    @(posedge clock);
    useP2 <= 1'b1;
    repeat (4) @(posedge clock);
    wr(ADDR_SHARED, 8'hd3);
    wr(ADDR_RUN, 8'h02);
    setLvl(1'b1);
    waitIrq(20);
    chk("no irq two", {7'h00, extIrqTwo}, 8'h00);
    rd(ADDR_SHARED);
    chk("other pin", v, 8'hd2);
    // Short pulse stays under the filter width, the held one passes
    for (int f = 1; f < 3; f++) begin
      setLvl(1'b0);
      repeat (40) @(posedge clock);
      wr(ADDR_SHARED, 8'hd2 | 8'(f << 2));
      setLvl(1'b1);
      repeat (3 * f) @(posedge clock);
      setLvl(1'b0);
      repeat (40) @(posedge clock);
      rd(ADDR_SHARED);
      chk("glitch", v, 8'hd0 | 8'(f << 2));
      setLvl(1'b1);
      repeat (40) @(posedge clock);
      rd(ADDR_SHARED);
      chk("held pulse", v, 8'hd2 | 8'(f << 2));
    end
    $display("test filter done");
    wr(ADDR_CNT8_CTL, 8'h22);
    waitIrq(1200);
    chk("timeout irq", {7'h00, timeoutIrq}, 8'h01);
    rd(ADDR_CNT8_CTL);
    chk("timeout flag", v, 8'h22);
    rd(ADDR_CNT8_VAL);
    chk("wrap", {7'h00, v >= 8'hf0}, 8'h01);
    $display("test timeout done");
    tallyAndFinish();
  end

  // Longest wait is one 8-bit timeout, near 510 clocks; the limit is generous
  initial begin
    repeat (20000) @(posedge clock);
    failCount++;
    tallyAndFinish();
  end
endmodule // test_dual_counter_common_control
